/* hdl/spce_pkg.sv */
// Purpose: Shared constants and types for the serial port control block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Register bytes sit in the low eight bits of each word
package spce_pkg;

  // Register byte addresses
  localparam logic [7:0] SPCE_CTRL_OFS   = 8'h00;
  localparam logic [7:0] SPCE_MODE_OFS   = 8'h04;
  localparam logic [7:0] SPCE_STATUS_OFS = 8'h08;
  localparam logic [7:0] SPCE_TXDATA_OFS = 8'h0c;
  localparam logic [7:0] SPCE_RXDATA_OFS = 8'h10;

  // Values after reset and after low-power entry
  localparam logic [7:0] SPCE_CTRL_RST   = 8'h00;
  localparam logic [7:0] SPCE_MODE_RST   = 8'h00;
  localparam logic [7:0] SPCE_STATUS_RST = 8'h84;
  localparam logic [7:0] SPCE_TXDATA_RST = 8'hff;
  localparam logic [7:0] SPCE_RXDATA_RST = 8'h00;

  // Bit positions in the mode register
  localparam int SPCE_MODE_COMM_BIT = 7;
  localparam int SPCE_MODE_MP_BIT   = 2;

  // Bit positions in the status register
  localparam int SPCE_ST_TX_EMPTY = 7;
  localparam int SPCE_ST_RX_FULL  = 6;
  localparam int SPCE_ST_OVERRUN  = 5;
  localparam int SPCE_ST_FRAMING  = 4;
  localparam int SPCE_ST_PARITY   = 3;
  localparam int SPCE_ST_TX_END   = 2;
  localparam int SPCE_ST_MPB      = 1;

  // Clock select codes {hi, lo}
  localparam logic [1:0] SPCE_CS_INTERNAL = 2'h0;
  localparam logic [1:0] SPCE_CS_INT_OUT  = 2'h1;
  localparam logic [1:0] SPCE_CS_EXTERNAL = 2'h2;

  // Serial control register, bit 7 down to bit 0
  typedef struct packed {
    logic tx_irq_enable;
    logic rx_irq_enable;
    logic tx_enable;
    logic rx_enable;
    logic multiproc_irq_enable;
    logic tx_end_irq_enable;
    logic clock_select_hi;
    logic clock_select_lo;
  } spce_ctrl_t;

  // End of a received character, reported by the receive shifter
  typedef struct packed {
    logic       done;
    logic [7:0] data;
    logic       mpbit;
    logic       frame_err;
    logic       parity_err;
  } spce_rx_evt_t;

endpackage

/* hdl/spce_serial_control.sv */
// Purpose: Control register, flags and interrupt levels of a serial port
// Assumes: Shifters and baud generator run on pclk and report by pulses
// Notes:   Pins rxd and sck_in are asynchronous and pass two flip-flops
`timescale 1ns/1ps

// Summary of operation
// - Control register clears to zero on reset and on low-power entry.
// - Transmit-empty request is flag AND transmit interrupt enable.
// - Receive interrupt enable gates receive-full and receive-error requests.
// - Requests drop when their flags or their interrupt enables are cleared.
// - Transmit disabled holds empty flag high, no start, pin stays data out.
// - With transmit enabled a data write clears empty flag and starts sending.
// - Receive disabled frees the pin; receive flags keep their state.
// - Reception starts on start bit (async) or serial clock edge (sync).
// - Multiprocessor enable acts only on async reception with multiprocessor mode.
// - While it acts, characters with multiprocessor bit zero are dropped without receive flags, errors or requests.
// - Character with multiprocessor bit one sets bit flag and clears enable.
// - Transmit-end request when last bit leaves with no data waiting.
// - Transmit-end request drops on a transmit data write or when its enable is cleared.
// - Clock select decodes pin function and clock source per mode.
// - Clock output in async mode runs at the bit rate.
// - Mode register bit 7 selects async (0) or sync (1).
module spce_serial_control (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  low_power_req,
  input  wire logic                  tx_load,
  input  wire logic                  tx_last_bit,
  input  wire logic                  tx_bit,
  input  wire spce_pkg::spce_rx_evt_t rx_evt,
  input  wire logic                  half_bit_tick,
  input  wire logic                  rxd,
  input  wire logic                  sck_in,
  output logic                       sck_out,
  output logic                       sck_oe_n,
  output logic                       txd,
  output logic                       rx_pin_is_port,
  output logic                       rx_begin,
  output logic                       tx_start,
  output logic      [7:0]            tx_data,
  output logic      [7:0]            mode_out,
  output logic                       ext_clock_sel,
  output logic                       tx_empty_irq,
  output logic                       rx_full_irq,
  output logic                       rx_error_irq,
  output logic                       tx_end_irq
);
  import spce_pkg::*;

  spce_ctrl_t ctrl_reg, ctrl_next;
  logic [7:0] mode_reg;
  logic [7:0] rx_holding_reg;
  logic       tx_empty_reg, rx_full_reg, overrun_reg, framing_reg, parity_reg;
  logic       tx_end_reg, mpb_reg;
  logic       tx_empty_next, rx_full_next, overrun_next, framing_next, parity_next;
  logic       tx_end_next;
  logic [7:3] seen_reg;
  logic       rxd_meta, rxd_sync, rxd_prev, sck_meta, sck_sync, sck_prev;
  logic       access, wr, rd, sync_mode, mp_mode, mp_active, rx_accept;
  logic       clr_tx_empty, clr_rx_full, clr_overrun, clr_framing, clr_parity;
  logic       tx_write, sck_drive;
  logic [7:0] status_byte;

  // Access phase with the answer given; zero wait states
  assign access = psel & penable & pready;
  assign wr     = access & pwrite;
  assign rd     = access & ~pwrite;

  assign sync_mode = mode_reg[SPCE_MODE_COMM_BIT];
  assign mp_mode   = mode_reg[SPCE_MODE_MP_BIT];
  // Multiprocessor filtering only in async reception with multiprocessor mode
  assign mp_active = ctrl_reg.multiproc_irq_enable & ~sync_mode & mp_mode;
  // A filtered character is dropped unless it carries the address mark
  assign rx_accept = rx_evt.done & (~mp_active | rx_evt.mpbit);

  assign status_byte = {tx_empty_reg, rx_full_reg, overrun_reg, framing_reg,
                        parity_reg, tx_end_reg, mpb_reg, 1'b0};
  assign tx_write    = wr && paddr == SPCE_TXDATA_OFS;

  // Flag clear: a zero written after the flag was read as one
  function automatic logic st_clr(input logic w, input logic [7:0] a,
                                  input logic [31:0] d, input logic seen, input int b);
    st_clr = w && a == SPCE_STATUS_OFS && !d[b] && seen;
  endfunction

  assign clr_tx_empty = st_clr(wr, paddr, pwdata, seen_reg[7], SPCE_ST_TX_EMPTY);
  assign clr_rx_full  = st_clr(wr, paddr, pwdata, seen_reg[6], SPCE_ST_RX_FULL)
                        | (rd && paddr == SPCE_RXDATA_OFS);
  assign clr_overrun  = st_clr(wr, paddr, pwdata, seen_reg[5], SPCE_ST_OVERRUN);
  assign clr_framing  = st_clr(wr, paddr, pwdata, seen_reg[4], SPCE_ST_FRAMING);
  assign clr_parity   = st_clr(wr, paddr, pwdata, seen_reg[3], SPCE_ST_PARITY);

  // Next control and flag values; hardware sets win over software clears
  always_comb begin
    ctrl_next = ctrl_reg;
    if (low_power_req) begin
      ctrl_next = SPCE_CTRL_RST;
    end else if (wr && paddr == SPCE_CTRL_OFS) begin
      ctrl_next = pwdata[7:0];
    end else if (rx_evt.done && mp_active && rx_evt.mpbit) begin
      ctrl_next.multiproc_irq_enable = 1'b0;
    end
    tx_empty_next = tx_empty_reg;
    if (!ctrl_reg.tx_enable || tx_load) begin
      tx_empty_next = 1'b1;
    end else if (tx_write || clr_tx_empty) begin
      tx_empty_next = 1'b0;
    end
    tx_end_next = tx_end_reg;
    if (tx_last_bit && tx_empty_reg) begin
      tx_end_next = 1'b1;
    end else if (tx_write) begin
      tx_end_next = 1'b0;
    end
    rx_full_next = rx_full_reg;
    if (rx_accept && !rx_full_reg && !rx_evt.frame_err && !rx_evt.parity_err) begin
      rx_full_next = 1'b1;
    end else if (clr_rx_full) begin
      rx_full_next = 1'b0;
    end
    overrun_next = (rx_accept && rx_full_reg) ? 1'b1 : (overrun_reg & ~clr_overrun);
    framing_next = (rx_accept && rx_evt.frame_err) ? 1'b1 : (framing_reg & ~clr_framing);
    parity_next  = (rx_accept && rx_evt.parity_err && !mp_mode) ? 1'b1
                   : (parity_reg & ~clr_parity);
  end

  // Control register; low-power entry clears it like reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= SPCE_CTRL_RST;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Mode register and transmit holding data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= SPCE_MODE_RST;
      tx_data  <= SPCE_TXDATA_RST;
    end else if (low_power_req) begin
      mode_reg <= SPCE_MODE_RST;
      tx_data  <= SPCE_TXDATA_RST;
    end else begin
      if (wr && paddr == SPCE_MODE_OFS) begin
        mode_reg <= pwdata[7:0];
      end
      if (tx_write) begin
        tx_data <= pwdata[7:0];
      end
    end
  end

  // Status flags and received data; receive enable never touches them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {tx_empty_reg, rx_full_reg, overrun_reg, framing_reg, parity_reg,
       tx_end_reg, mpb_reg} <= SPCE_STATUS_RST[7:1];
      rx_holding_reg <= SPCE_RXDATA_RST;
    end else if (low_power_req) begin
      {tx_empty_reg, rx_full_reg, overrun_reg, framing_reg, parity_reg,
       tx_end_reg, mpb_reg} <= SPCE_STATUS_RST[7:1];
      rx_holding_reg <= SPCE_RXDATA_RST;
    end else begin
      tx_empty_reg <= tx_empty_next;
      tx_end_reg   <= tx_end_next;
      rx_full_reg  <= rx_full_next;
      overrun_reg  <= overrun_next;
      framing_reg  <= framing_next;
      parity_reg   <= parity_next;
      if (rx_full_next && !rx_full_reg) begin
        rx_holding_reg <= rx_evt.data;
      end
      if (rx_evt.done && mp_mode && !sync_mode) begin
        mpb_reg <= rx_evt.mpbit;
      end
    end
  end

  // Remember which flags were read as one, so a blind zero write clears nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_reg <= 5'h00;
    end else if (rd && paddr == SPCE_STATUS_OFS) begin
      seen_reg <= status_byte[7:3];
    end else if (wr && paddr == SPCE_STATUS_OFS) begin
      seen_reg <= 5'h00;
    end
  end

  // Requests registered from next values so they move with their flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_empty_irq <= 1'b0;
      rx_full_irq  <= 1'b0;
      rx_error_irq <= 1'b0;
      tx_end_irq   <= 1'b0;
    end else if (low_power_req) begin
      tx_empty_irq <= 1'b0;
      rx_full_irq  <= 1'b0;
      rx_error_irq <= 1'b0;
      tx_end_irq   <= 1'b0;
    end else begin
      tx_empty_irq <= tx_empty_next & ctrl_next.tx_irq_enable;
      rx_full_irq  <= rx_full_next & ctrl_next.rx_irq_enable;
      rx_error_irq <= (overrun_next | framing_next | parity_next)
                      & ctrl_next.rx_irq_enable;
      tx_end_irq   <= tx_end_next & ctrl_next.tx_end_irq_enable;
    end
  end

  // APB answer prepared in the setup cycle; unmapped addresses flag an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        if (paddr == SPCE_CTRL_OFS) begin
          prdata <= {24'h00_0000, ctrl_reg};
        end else if (paddr == SPCE_MODE_OFS) begin
          prdata <= {24'h00_0000, mode_reg};
        end else if (paddr == SPCE_STATUS_OFS) begin
          prdata <= {24'h00_0000, status_byte};
        end else if (paddr == SPCE_TXDATA_OFS) begin
          prdata <= {24'h00_0000, tx_data};
        end else if (paddr == SPCE_RXDATA_OFS) begin
          prdata <= {24'h00_0000, rx_holding_reg};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {rxd_meta, rxd_sync, rxd_prev} <= 3'h7;
      {sck_meta, sck_sync, sck_prev} <= 3'h7;  // Link clock idles high
    end else begin
      {rxd_meta, rxd_sync, rxd_prev} <= {rxd, rxd_meta, rxd_sync};
      {sck_meta, sck_sync, sck_prev} <= {sck_in, sck_meta, sck_sync};
    end
  end

  // Transmit start and receive start pulses, pin roles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_start       <= 1'b0;
      rx_begin       <= 1'b0;
      txd            <= 1'b1;
      rx_pin_is_port <= 1'b1;
    end else begin
      tx_start <= tx_write & ctrl_reg.tx_enable;
      rx_begin <= ctrl_reg.rx_enable &
                  (sync_mode ? (sck_sync & ~sck_prev) : (~rxd_sync & rxd_prev));
      txd            <= tx_bit;
      rx_pin_is_port <= ~ctrl_reg.rx_enable;
    end
  end

  // Clock pin drive: async with output select, or sync on the internal clock
  assign sck_drive =
    ({ctrl_reg.clock_select_hi, ctrl_reg.clock_select_lo} == SPCE_CS_INT_OUT && !sync_mode) ||
    ({ctrl_reg.clock_select_hi, ctrl_reg.clock_select_lo} == SPCE_CS_INTERNAL && sync_mode);

  // Toggling every half bit gives one clock period per bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_out       <= 1'b1;
      sck_oe_n      <= 1'b1;
      ext_clock_sel <= 1'b0;
      mode_out      <= SPCE_MODE_RST;
    end else begin
      sck_oe_n      <= ~sck_drive;
      sck_out       <= !sck_drive ? 1'b1 : (half_bit_tick ? ~sck_out : sck_out);
      ext_clock_sel <= {ctrl_reg.clock_select_hi, ctrl_reg.clock_select_lo}
                       == SPCE_CS_EXTERNAL;
      mode_out      <= mode_reg;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_lp_entry; low_power_req; endsequence
  property p_ctrl_clear;
    s_lp_entry |=> ctrl_reg == SPCE_CTRL_RST && !tx_empty_irq;
  endproperty
  a_ctrl_clear: assert property (p_ctrl_clear) else $error("control not cleared");

  property p_tx_irq;
    tx_empty_irq == (tx_empty_reg & ctrl_reg.tx_irq_enable);
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("tx empty irq mismatch");

  property p_rx_gate;
    !ctrl_reg.rx_irq_enable && !low_power_req && !(wr && paddr == SPCE_CTRL_OFS)
      |=> !rx_full_irq && !rx_error_irq;
  endproperty
  a_rx_gate: assert property (p_rx_gate) else $error("rx irq not gated");

  property p_rx_drop;
    clr_rx_full && !rx_evt.done |=> !rx_full_irq;
  endproperty
  a_rx_drop: assert property (p_rx_drop) else $error("rx irq not dropped");

  property p_te_off;
    !ctrl_reg.tx_enable && !low_power_req |=> tx_empty_reg && !tx_start;
  endproperty
  a_te_off: assert property (p_te_off) else $error("tx disabled but not idle");

  sequence s_data_write; tx_write && ctrl_reg.tx_enable && !tx_load; endsequence
  property p_tx_go;
    s_data_write |=> tx_start && !tx_empty_reg ##1 !tx_start;
  endproperty
  a_tx_go: assert property (p_tx_go) else $error("write did not start tx");

  property p_re_keep;
    $fell(ctrl_reg.rx_enable) && !$past(low_power_req) && !$past(rx_evt.done)
      && !$past(clr_rx_full) && !$past(clr_overrun) |-> $stable({rx_full_reg, overrun_reg});
  endproperty
  a_re_keep: assert property (p_re_keep) else $error("rx flags changed");

  property p_filter;
    rx_evt.done && mp_active && !rx_evt.mpbit && !(clr_rx_full | clr_overrun | clr_framing)
      && !low_power_req |=> $stable({rx_full_reg, framing_reg, overrun_reg});
  endproperty
  a_filter: assert property (p_filter) else $error("filtered char set flags");

  property p_wake;
    rx_evt.done && mp_active && rx_evt.mpbit && !low_power_req && !wr
      |=> mpb_reg && !ctrl_reg.multiproc_irq_enable;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not taken");

  property p_tx_end;
    tx_last_bit && tx_empty_reg && ctrl_reg.tx_end_irq_enable && !low_power_req
      && !(wr && paddr == SPCE_CTRL_OFS) |=> tx_end_irq;
  endproperty
  a_tx_end: assert property (p_tx_end) else $error("no tx end irq");

  property p_sck_out;
    sck_drive && half_bit_tick |=> sck_out != $past(sck_out) && !sck_oe_n;
  endproperty
  a_sck_out: assert property (p_sck_out) else $error("clock out stuck");
endmodule // spce_serial_control

/* verification/spce_remote_station.sv */
// Purpose: Remote serial station that sends framed characters to the port
// Assumes: One bit per link clock period of 400 ns, link clock idles high
// Notes:   Also reports each character sent with report set, as the receive shifter would
`timescale 1ns/1ps
module spce_remote_station (
  input  wire logic             pclk,
  output logic                  rxd,
  output logic                  sck_in,
  output spce_pkg::spce_rx_evt_t rx_evt
);
  import spce_pkg::*;

  // Line idles at mark level, link clock stands still outside frames
  initial begin
    rxd    = 1'b1;
    sck_in = 1'b1;
    rx_evt = '0;
  end

  // Start bit, data LSB first, multiprocessor bit, stop bit
  task automatic send_char(input logic [7:0] d, input logic mpb, input logic report);
    logic [10:0] fr;
    fr = {1'b1, mpb, d, 1'b0};
    @(posedge pclk);
    #37; // Link clock phase kept unrelated to pclk
    for (int i = 0; i < 11; i++) begin
      rxd    = fr[i];
      sck_in = 1'b0;
      #200;
      sck_in = 1'b1;
      #200;
    end
    rxd = 1'b1;
    // Shifter report only exists while reception is enabled
    if (report) begin
      @(posedge pclk);
      rx_evt <= {1'b1, d, mpb, 1'b0, 1'b0};
      @(posedge pclk);
      rx_evt <= {1'b0, ~d, ~mpb, 1'b0, 1'b0}; // Stale data is not left standing
    end
  endtask
endmodule // spce_remote_station

/* verification/spce_serial_control_test.sv */
// Purpose: Self-checking bench for the serial port control block
// Assumes: APB answers with pready, irqs are registered levels
// Notes:   Reads are scored by a monitor from a queue of expectations
`timescale 1ns/1ps
module spce_serial_control_test;
  import spce_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic low_power_req, tx_load, tx_last_bit, tx_bit, half_bit_tick, rxd, sck_in;
  logic sck_out, sck_oe_n, txd, rx_pin_is_port, rx_begin, tx_start, ext_clock_sel;
  logic tx_empty_irq, rx_full_irq, rx_error_irq, tx_end_irq;
  logic [7:0]  paddr, tx_data, mode_out, d1, d2, s;
  logic [31:0] pwdata, prdata;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  spce_rx_evt_t rx_evt;
  int failures = 0;
  int checked = 0;
  int begins = 0;
  int nb;
  logic drv;

  spce_serial_control i_spce_serial_control (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .low_power_req(low_power_req), .tx_load(tx_load),
    .tx_last_bit(tx_last_bit), .tx_bit(tx_bit), .rx_evt(rx_evt),
    .half_bit_tick(half_bit_tick), .rxd(rxd), .sck_in(sck_in), .sck_out(sck_out),
    .sck_oe_n(sck_oe_n), .txd(txd), .rx_pin_is_port(rx_pin_is_port), .rx_begin(rx_begin),
    .tx_start(tx_start), .tx_data(tx_data), .mode_out(mode_out),
    .ext_clock_sel(ext_clock_sel), .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq),
    .rx_error_irq(rx_error_irq), .tx_end_irq(tx_end_irq));

  spce_remote_station i_spce_remote_station (.pclk(pclk), .rxd(rxd), .sck_in(sck_in),
    .rx_evt(rx_evt));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Read monitor takes the oldest expectation at each read access edge
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1ffffffff;
      checked++;
      if ({pslverr, prdata} !== e) begin
        failures++;
        $display("[ERR] read expected %h seen %h", e, {pslverr, prdata});
      end
    end
  end

  // Receive starts seen so far
  always @(posedge pclk) begin
    if (rx_begin === 1'b1) begins++;
  end

  task automatic conclude;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    checked++;
    if (got !== ex) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // One APB transfer, request held until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] ex);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    if (!wr) exp_q.push_back(ex);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      failures++;
      $display("[ERR] pready expected 1 seen 0");
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d}, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic err = 1'b0);
    xfer(1'b0, a, 32'h0, {err, 24'h0, d});
  endtask

  // Levels are looked at once the cause has had time to land
  task automatic settle;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic pulse(input int which);
    @(posedge pclk);
    if (which == 0) tx_load <= 1'b1;
    if (which == 1) tx_last_bit <= 1'b1;
    if (which == 2) half_bit_tick <= 1'b1;
    @(posedge pclk);
    tx_load       <= 1'b0;
    tx_last_bit   <= 1'b0;
    half_bit_tick <= 1'b0;
    settle();
  endtask

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; low_power_req = 1'b0; tx_load = 1'b0; tx_last_bit = 1'b0;
    tx_bit = 1'b1; half_bit_tick = 1'b0;
    void'($urandom(93205));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(SPCE_CTRL_OFS, SPCE_CTRL_RST);
    rd(SPCE_STATUS_OFS, SPCE_STATUS_RST);
    rd(8'h14, 8'h00, 1'b1);
    s = 8'($urandom);
    wr(SPCE_CTRL_OFS, s);
    rd(SPCE_CTRL_OFS, s);
    @(posedge pclk) low_power_req <= 1'b1;
    @(posedge pclk) low_power_req <= 1'b0;
    rd(SPCE_CTRL_OFS, 8'h00);
    done("reset");
    // Transmit gating, empty and end requests
    tx_bit <= 1'b0;
    wr(SPCE_TXDATA_OFS, 8'h3c);
    @(negedge pclk) chk("tx_start", 8'h0, tx_start);
    settle();
    chk("txd", 8'h0, txd);
    rd(SPCE_STATUS_OFS, 8'h80);
    wr(SPCE_CTRL_OFS, 8'ha4);
    wr(SPCE_TXDATA_OFS, 8'h5a);
    @(negedge pclk) chk("tx_start", 8'h1, tx_start);
    settle();
    chk("tx_data", 8'h5a, tx_data);
    chk("tx_empty_irq", 8'h0, tx_empty_irq);
    pulse(0);
    chk("tx_empty_irq", 8'h1, tx_empty_irq);
    pulse(1);
    chk("tx_end_irq", 8'h1, tx_end_irq);
    wr(SPCE_CTRL_OFS, 8'h20);
    settle();
    chk("tx_empty_irq", 8'h0, tx_empty_irq);
    chk("tx_end_irq", 8'h0, tx_end_irq);
    done("transmit");
    // Receive requests, overrun, disable keeps flags
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    wr(SPCE_CTRL_OFS, 8'h50);
    i_spce_remote_station.send_char(d1, 1'b0, 1'b1);
    settle();
    chk("rx_begin count", 8'h1, 8'(begins != 0));
    chk("rx_full_irq", 8'h1, rx_full_irq);
    i_spce_remote_station.send_char(d2, 1'b0, 1'b1);
    settle();
    chk("rx_error_irq", 8'h1, rx_error_irq);
    wr(SPCE_CTRL_OFS, 8'h10);
    settle();
    chk("rx irqs", 8'h0, {rx_full_irq, rx_error_irq});
    wr(SPCE_CTRL_OFS, 8'h00);
    settle();
    chk("rx_pin_is_port", 8'h1, rx_pin_is_port);
    nb = begins;
    i_spce_remote_station.send_char(d2, 1'b0, 1'b0);
    chk("rx_begin count", 8'h1, 8'(nb == begins));
    rd(SPCE_STATUS_OFS, 8'he4);
    rd(SPCE_RXDATA_OFS, d1);
    wr(SPCE_CTRL_OFS, 8'h50);
    settle();
    chk("rx irqs", 8'h1, {rx_full_irq, rx_error_irq});
    wr(SPCE_STATUS_OFS, 8'h00);
    settle();
    chk("rx_error_irq", 8'h0, rx_error_irq);
    done("receive");
    // Multiprocessor filtering and its automatic clear
    wr(SPCE_MODE_OFS, 8'h04);
    wr(SPCE_CTRL_OFS, 8'h58);
    i_spce_remote_station.send_char(d1, 1'b0, 1'b1);
    settle();
    chk("rx_full_irq", 8'h0, rx_full_irq);
    rd(SPCE_STATUS_OFS, 8'h84);
    i_spce_remote_station.send_char(d2, 1'b1, 1'b1);
    settle();
    chk("rx_full_irq", 8'h1, rx_full_irq);
    rd(SPCE_CTRL_OFS, 8'h50);
    rd(SPCE_STATUS_OFS, 8'hc6);
    rd(SPCE_RXDATA_OFS, d2);
    wr(SPCE_MODE_OFS, 8'h84);
    wr(SPCE_CTRL_OFS, 8'h58);
    i_spce_remote_station.send_char(d1, 1'b0, 1'b1);
    settle();
    chk("rx_full_irq", 8'h1, rx_full_irq);
    rd(SPCE_RXDATA_OFS, d1);
    done("multiprocessor");
    // Every clock select code in both communication modes
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 4; c++) begin
        wr(SPCE_CTRL_OFS, 8'(c));
        wr(SPCE_MODE_OFS, {m[0], 7'h0});
        settle();
        drv = (c == 1 && m == 0) || (c == 0 && m == 1);
        chk("sck_oe_n", 8'(!drv), sck_oe_n);
        chk("ext_clock_sel", 8'(c == 2), ext_clock_sel);
        chk("mode_out", {m[0], 7'h0}, mode_out);
        if (drv && m == 0) begin
          s = 8'(sck_out);
          pulse(2);
          chk("sck_out", 8'(!s[0]), sck_out);
        end
      end
    end
    done("clock select");
    conclude();
  end
endmodule // spce_serial_control_test
